// [hw/mie_defs.svh]
// Operation
// RULE1: skip-zero move: load acc, skip if zero
// RULE2: bit test: skip when bit zero, no flags
// RULE3: paged table read: both pointers, low/high split
// RULE4: last-page table read uses pointer low only
// RULE5: paged read after pointer low increment
// RULE6: last-page read after pointer low increment
// RULE7: xor to acc or memory, zero flag
// RULE8: extended forms reach every memory section
// RULE9: add with/without carry, five flags
// RULE10: and to acc or memory, zero flag
// RULE11: clear byte or bit, no flags
// RULE12: invert to memory or acc, zero flag
// RULE13: decimal adjust adds 06H/60H, to memory
// RULE14: decimal adjust changes carry only
// RULE15: decrement to memory or acc, zero flag
// RULE16: increment to memory or acc, zero flag
// RULE17: move between acc and memory, no flags
// RULE18: or to acc or memory, zero flag
// RULE19: rotate left, bit 7 into bit 0
// RULE20: extended skip taken costs three cycles
// RULE21: zero flag from eight-bit result only
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH
`define MIE_ACC_RST 8'h00
`define MIE_TBL_RST 8'h00
`define MIE_ZERO8 8'h00
`define MIE_ONE8 8'h01
`define MIE_DAA_LO 8'h06
`define MIE_DAA_HI 8'h60
`define MIE_NIB_MAX 4'h9
`define MIE_CYC_SKIP 2'h2
`define MIE_CYC_LSKIP 2'h3
`define MIE_CYC_ONE 2'h1
`endif

// [hw/mie_pkg.sv]
package mie_pkg;
  typedef enum logic [4:0] {
    MIE_NOP, MIE_SZA, MIE_SZ_BIT, MIE_TABLE_READ_PAGED_P, MIE_TABLE_READ_PAGED_L, MIE_INC_TABLE_READ_PAGED_P, MIE_INC_TABLE_READ_PAGED_L,
    MIE_XOR, MIE_ADD, MIE_AND, MIE_OR, MIE_CLR, MIE_CLR_BIT, MIE_CPL, MIE_DAA,
    MIE_DEC, MIE_INC, MIE_MOV_TO_ACC, MIE_MOV_TO_MEM, MIE_RL
  } mie_op_t;
  typedef struct packed {
    mie_op_t op;
    logic use_carry;
    logic to_mem;
    logic use_imm;
    logic extended;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } mie_cmd_t;
  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry;
    logic sign_carry_flag;
  } mie_flags_t;
endpackage

// [hw/mie_alu.sv]
`include "mie_defs.svh"
module mie_alu import mie_pkg::*; (
  // operands
  input wire mie_cmd_t cmd,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire mie_flags_t flags_in,
  // results
  output mie_flags_t flags_out,
  output logic [7:0] result,
  output logic skip
);
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] opnd;
  logic [7:0] adj;
  logic [8:0] daa_sum;
  always_comb begin
    opnd = cmd.use_imm ? cmd.imm : mem;
    sum = {1'b0, acc} + {1'b0, mem} + {8'h00, cmd.use_carry & flags_in.carry}; // RULE9
    half = {1'b0, acc[3:0]} + {1'b0, mem[3:0]} + {4'h0, cmd.use_carry & flags_in.carry};
    adj = `MIE_ZERO8;
    if (acc[3:0] > `MIE_NIB_MAX || flags_in.aux_carry_flag) begin
      adj = adj | `MIE_DAA_LO; // RULE13
    end
    if (acc[7:4] > `MIE_NIB_MAX || flags_in.carry) begin
      adj = adj | `MIE_DAA_HI; // RULE13
    end
    daa_sum = {1'b0, acc} + {1'b0, adj};
    result = mem;
    flags_out = flags_in;
    skip = 1'b0;
    unique case (cmd.op)
      MIE_SZA: begin
        result = mem; // RULE1
        skip = (mem == `MIE_ZERO8);
      end
      MIE_SZ_BIT: skip = ~mem[cmd.bit_sel]; // RULE2
      MIE_XOR: result = acc ^ opnd; // RULE7
      MIE_ADD: begin
        result = sum[7:0];
        flags_out.carry = sum[8]; // RULE9
        flags_out.aux_carry_flag = half[4];
        flags_out.overflow_flag = (acc[7] == mem[7]) && (sum[7] != acc[7]);
        // sign carry: result msb against the carry into bit 7
        flags_out.sign_carry_flag = sum[7] ^ (acc[7] ^ mem[7] ^ sum[7]);
      end
      MIE_AND: result = acc & mem; // RULE10
      MIE_OR: result = acc | mem; // RULE18
      MIE_CLR: result = `MIE_ZERO8; // RULE11
      MIE_CLR_BIT: begin
        result = mem;
        result[cmd.bit_sel] = 1'b0; // RULE11
      end
      MIE_CPL: result = ~mem; // RULE12
      MIE_DAA: begin
        result = daa_sum[7:0];
        flags_out.carry = flags_in.carry | daa_sum[8]; // RULE14
      end
      MIE_DEC: result = mem - `MIE_ONE8; // RULE15
      MIE_INC: result = mem + `MIE_ONE8; // RULE16
      MIE_MOV_TO_ACC: result = mem; // RULE17
      MIE_MOV_TO_MEM: result = acc; // RULE17
      MIE_RL: result = {mem[6:0], mem[7]}; // RULE19
      default: result = mem;
    endcase
    // zero flag only for the flag-affecting ops
    if (cmd.op inside {MIE_XOR, MIE_ADD, MIE_AND, MIE_OR, MIE_CPL, MIE_DEC, MIE_INC}) begin
      flags_out.zero_flag = (result == `MIE_ZERO8); // RULE21
    end
  end
endmodule

// [hw/mie_core.sv]
`include "mie_defs.svh"
module mie_core import mie_pkg::*; #(
  parameter int ADDR_W = 9,
  parameter int PROG_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // command
  input wire logic cmd_valid,
  input wire mie_cmd_t cmd,
  output logic cmd_ready,
  // data memory, full-width address reaches every section
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire logic [7:0] mem_rdata,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_waddr,
  output logic [7:0] mem_wdata,
  // program memory table port
  output logic [15:0] prog_addr,
  input wire logic [PROG_W-1:0] prog_rdata,
  input wire logic [7:0] last_page_hi,
  // table pointers
  input wire logic tbl_low_we,
  input wire logic tbl_high_we,
  input wire logic [7:0] tbl_wdata,
  output logic [7:0] table_pointer_low,
  output logic [7:0] table_pointer_high,
  output logic [7:0] table_high_latch,
  // architectural state
  output logic [7:0] acc,
  output mie_flags_t flags,
  output logic skip_next,
  output logic [1:0] cycles_used
);
  initial begin
    if (ADDR_W < 1 || ADDR_W > 16 || PROG_W != 16) begin
      $error("mie_core: unsupported width");
    end
  end
  mie_flags_t alu_flags;
  logic [7:0] alu_res;
  logic alu_skip;
  logic [7:0] next_tbl_low;
  logic is_table;
  logic is_inc;
  logic go;
  assign cmd_ready = 1'b1;
  assign go = cmd_valid;
  mie_alu u_alu (
    .cmd(cmd),
    .acc(acc),
    .mem(mem_rdata),
    .flags_in(flags),
    .flags_out(alu_flags),
    .result(alu_res),
    .skip(alu_skip)
  );
  // ----------------------------------------
  // table addressing
  // ----------------------------------------
  assign is_table = cmd.op inside {MIE_TABLE_READ_PAGED_P, MIE_TABLE_READ_PAGED_L, MIE_INC_TABLE_READ_PAGED_P, MIE_INC_TABLE_READ_PAGED_L};
  assign is_inc = cmd.op inside {MIE_INC_TABLE_READ_PAGED_P, MIE_INC_TABLE_READ_PAGED_L};
  // increment lands before the fetch, same cycle
  assign next_tbl_low = is_inc ? table_pointer_low + `MIE_ONE8 : table_pointer_low; // RULE5 RULE6
  always_comb begin
    if (cmd.op inside {MIE_TABLE_READ_PAGED_L, MIE_INC_TABLE_READ_PAGED_L}) begin
      prog_addr = {last_page_hi, next_tbl_low}; // RULE4 RULE6
    end else begin
      prog_addr = {table_pointer_high, next_tbl_low}; // RULE3 RULE5
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      table_pointer_low <= `MIE_TBL_RST;
    end else if (go && is_inc) begin
      table_pointer_low <= next_tbl_low; // RULE5 RULE6
    end else if (tbl_low_we) begin
      table_pointer_low <= tbl_wdata;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      table_pointer_high <= `MIE_TBL_RST;
    end else if (tbl_high_we) begin
      table_pointer_high <= tbl_wdata;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      table_high_latch <= `MIE_TBL_RST;
    end else if (go && is_table) begin
      table_high_latch <= prog_rdata[15:8]; // RULE3 RULE4
    end
  end
  // ----------------------------------------
  // memory write-back
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_we <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= `MIE_ZERO8;
    end else begin
      mem_waddr <= mem_addr_in; // RULE8
      mem_we <= 1'b0;
      if (go) begin
        unique case (cmd.op)
          MIE_TABLE_READ_PAGED_P, MIE_TABLE_READ_PAGED_L, MIE_INC_TABLE_READ_PAGED_P, MIE_INC_TABLE_READ_PAGED_L: begin
            mem_we <= 1'b1;
            mem_wdata <= prog_rdata[7:0]; // RULE3 RULE4
          end
          MIE_CLR, MIE_CLR_BIT, MIE_DAA, MIE_RL, MIE_CPL, MIE_DEC, MIE_INC, MIE_MOV_TO_MEM: begin
            mem_we <= cmd.to_mem | (cmd.op inside {MIE_CLR, MIE_CLR_BIT, MIE_DAA, MIE_MOV_TO_MEM}); // RULE13
            mem_wdata <= alu_res;
          end
          MIE_XOR, MIE_ADD, MIE_AND, MIE_OR: begin
            mem_we <= cmd.to_mem & ~cmd.use_imm; // RULE7
            mem_wdata <= alu_res;
          end
          default: mem_we <= 1'b0;
        endcase
      end
    end
  end
  // ----------------------------------------
  // accumulator and flags
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc <= `MIE_ACC_RST;
    end else if (go) begin
      if (cmd.op == MIE_SZA || cmd.op == MIE_MOV_TO_ACC) begin
        acc <= alu_res; // RULE1 RULE17
      end else if (!cmd.to_mem && cmd.op inside {MIE_XOR, MIE_ADD, MIE_AND, MIE_OR, MIE_CPL,
                                                  MIE_DEC, MIE_INC, MIE_RL}) begin
        acc <= alu_res; // RULE12 RULE15 RULE16 RULE19
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else if (go) begin
      flags <= alu_flags; // RULE21
    end
  end
  // ----------------------------------------
  // skip and cycle cost
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      skip_next <= 1'b0;
      cycles_used <= `MIE_CYC_ONE;
    end else if (go) begin
      skip_next <= alu_skip; // RULE1 RULE2
      if (alu_skip) begin
        // dummy fetch slot, one more for extended
        cycles_used <= cmd.extended ? `MIE_CYC_LSKIP : `MIE_CYC_SKIP; // RULE20
      end else begin
        cycles_used <= `MIE_CYC_ONE;
      end
    end else begin
      skip_next <= 1'b0;
    end
  end
endmodule

// [bench/mie_core_checker.sv]
// ------
// checker
// ------
module mie_core_checker import mie_pkg::*; #(
  parameter int PROG_W = 16
) (
  // inputs
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire mie_cmd_t cmd,
  input wire logic [7:0] mem_rdata,
  input wire logic [PROG_W-1:0] prog_rdata,
  input wire logic [7:0] last_page_hi,
  // outputs
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] table_pointer_low,
  input wire logic [7:0] table_high_latch,
  input wire logic [7:0] acc,
  input wire mie_flags_t flags,
  input wire logic skip_next
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire mie_op_t op = cmd_valid ? cmd.op : MIE_NOP;
  chk_move_then_skip: assert property (op == MIE_SZA |=> acc == $past(mem_rdata) &&
    skip_next == ($past(mem_rdata) == 8'h00)) else $error("move skip wrong");
  chk_bit_test_skip: assert property (op == MIE_SZ_BIT && !mem_rdata[cmd.bit_sel] |=>
    skip_next && $stable(flags)) else $error("bit skip wrong");
  chk_table_word_split: assert property (op inside {MIE_TABLE_READ_PAGED_P, MIE_INC_TABLE_READ_PAGED_P, MIE_INC_TABLE_READ_PAGED_L} |=> mem_we &&
    mem_wdata == $past(prog_rdata[7:0]) && table_high_latch == $past(prog_rdata[15:8])) else $error("table wrong");
  chk_last_page_addr: assert property (op == MIE_TABLE_READ_PAGED_L |->
    prog_addr == {last_page_hi, table_pointer_low}) else $error("last page wrong");
  chk_inc_before_read: assert property (op == MIE_INC_TABLE_READ_PAGED_P |-> prog_addr[7:0] == table_pointer_low + 8'h01
    ##1 table_pointer_low == $past(table_pointer_low) + 8'h01) else $error("pointer inc wrong");
  chk_xor_zero_flag: assert property (op == MIE_XOR && !cmd.to_mem && !cmd.use_imm |=>
    acc == ($past(acc) ^ $past(mem_rdata)) && flags.zero_flag == (acc == 8'h00)) else $error("xor wrong");
  chk_rotate_to_mem: assert property (op == MIE_RL && cmd.to_mem |=> mem_we && $stable(flags) &&
    mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) else $error("rotate wrong");
  chk_dec_to_acc: assert property (op == MIE_DEC && !cmd.to_mem |=> !mem_we &&
    acc == $past(mem_rdata) - 8'h01) else $error("decrement wrong");
  cover property (skip_next);
  cover property (op == MIE_ADD);
  cover property (op == MIE_DAA);
endmodule

// [bench/tb_top.sv]
// ------
// bench
// ------
module tb_top import mie_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, mem_we, skip_next, tbl_high_we = 1'b0;
  logic [7:0] tbl_wdata = 8'h12;
  logic [1:0] cycles_used;
  logic [8:0] mem_addr_in = 9'h1A5, mem_waddr;
  logic [7:0] mem_rdata = 8'h00, mem_wdata, table_pointer_low, table_pointer_high, table_high_latch, acc;
  logic [15:0] prog_rdata = 16'hA55A, prog_addr, pa;
  mie_cmd_t cmd = '0;
  mie_flags_t flags;
  int miscompares = 0, comparisons = 0;
  always #10 clk_sys = ~clk_sys;
  // low pointer load tied off: it moves only through the incrementing reads
  mie_core u_mie_core (.clk_sys, .rst, .cmd_valid, .cmd, .cmd_ready(), .mem_addr_in, .mem_rdata, .mem_we,
    .mem_waddr, .mem_wdata, .prog_addr, .prog_rdata, .last_page_hi(8'h3F), .tbl_low_we(1'b0),
    .tbl_high_we, .tbl_wdata, .table_pointer_low, .table_pointer_high, .table_high_latch,
    .acc, .flags, .skip_next, .cycles_used);
  task automatic cmp(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  // f is use_carry, to_mem, use_imm, extended; idle edge keeps drives apart
  task automatic run(mie_op_t op, logic [7:0] m, logic [3:0] f = 4'h0, logic [2:0] bs = 3'h7);
    @(posedge clk_sys);
    #1;
    cmd = {op, f, bs, 8'h3C};
    mem_rdata = m;
    cmd_valid = 1'b1;
    #9;
    pa = prog_addr;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
  endtask
  task automatic s_skip();
    cmp("cycles", 16'(cycles_used), 16'h1);
    run(MIE_SZA, 8'h00);
    cmp("cycles", 16'(cycles_used), 16'h2);
    run(MIE_SZA, 8'h00, 4'h1);
    cmp("cycles", 16'(cycles_used), 16'h3);
    run(MIE_SZ_BIT, 8'h7F);
    cmp("skip", 16'(skip_next), 16'h1);
  endtask
  task automatic s_tbl();
    @(posedge clk_sys);
    #1;
    tbl_high_we = 1'b1;
    @(posedge clk_sys);
    #1;
    tbl_high_we = 1'b0;
    cmp("tph", 16'(table_pointer_high), 16'h12);
    run(MIE_INC_TABLE_READ_PAGED_P, 8'h00);
    cmp("addr", pa, 16'h1201);
    cmp("latch", 16'(table_high_latch), 16'hA5);
    cmp("wdata", 16'(mem_wdata), 16'h5A);
    run(MIE_INC_TABLE_READ_PAGED_L, 8'h00);
    cmp("addr", pa, 16'h3F02);
    run(MIE_TABLE_READ_PAGED_P, 8'h00);
    cmp("addr", pa, 16'h1202);
    run(MIE_TABLE_READ_PAGED_L, 8'h00);
    cmp("addr", pa, 16'h3F02);
  endtask
  task automatic s_logic();
    run(MIE_MOV_TO_ACC, 8'h0F);
    cmp("acc", 16'(acc), 16'hF);
    run(MIE_XOR, 8'h0F);
    cmp("zero", 16'(flags.zero_flag), 16'h1);
    run(MIE_XOR, 8'h00, 4'h2);
    cmp("acc", 16'(acc), 16'h3C);
    run(MIE_XOR, 8'h3C, 4'h4);
    cmp("waddr", 16'(mem_waddr), 16'h1A5);
    run(MIE_AND, 8'h0F);
    cmp("acc", 16'(acc), 16'hC);
    run(MIE_OR, 8'hC0, 4'h4);
    cmp("wdata", 16'(mem_wdata), 16'hCC);
  endtask
  task automatic s_arith();
    run(MIE_MOV_TO_ACC, 8'h7F);
    run(MIE_ADD, 8'h01);
    cmp("flags", 16'(flags), 16'h14);
    run(MIE_ADD, 8'h80, 4'h4);
    cmp("flags", 16'(flags), 16'h1A);
    run(MIE_ADD, 8'h00, 4'h8);
    cmp("acc", 16'(acc), 16'h81);
    run(MIE_MOV_TO_ACC, 8'hA3);
    run(MIE_DAA, 8'h00);
    cmp("wdata", 16'(mem_wdata), 16'h3);
    cmp("flags", 16'(flags), 16'h3);
  endtask
  task automatic s_unary();
    run(MIE_CLR_BIT, 8'hFF, 4'h4, 3'h3);
    cmp("wdata", 16'(mem_wdata), 16'hF7);
    run(MIE_CPL, 8'hFF);
    cmp("we", 16'(mem_we), 16'h0);
    cmp("acc", 16'(acc), 16'h0);
    cmp("zero", 16'(flags.zero_flag), 16'h1);
    run(MIE_INC, 8'hFF, 4'h4);
    cmp("wdata", 16'(mem_wdata), 16'h0);
    run(MIE_DEC, 8'h01);
    cmp("acc", 16'(acc), 16'h0);
    run(MIE_RL, 8'h81, 4'h4);
    cmp("wdata", 16'(mem_wdata), 16'h3);
    run(MIE_RL, 8'h40);
    cmp("acc", 16'(acc), 16'h80);
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    s_skip();
    s_tbl();
    s_logic();
    s_arith();
    s_unary();
    close_out();
  end
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
endmodule
bind mie_core mie_core_checker #(.PROG_W(PROG_W)) u_mie_core_checker (.clk_sys, .rst, .cmd_valid, .cmd,
  .mem_rdata, .prog_rdata, .last_page_hi, .mem_we, .mem_wdata, .prog_addr, .table_pointer_low,
  .table_high_latch, .acc, .flags, .skip_next);
